/* core/ifa_top.sv */
// Purpose: route seven input terminals to control functions by code
// Assumes: codes and levels held steady by the parameter store
// Notes: network inputs arrive already on the clock domain
`timescale 1ns/1ps
`default_nettype none
// How it works
// - seven terminals, each with its own code
// - factory codes 1,2,19,48,24,20,22
// - code zero drives nothing
// - code 1 is forward run
// - code 2 is backward run
// - code 19 selects halt style
// - code 22 overheat halt, or-ed like the other shared functions
// - code 24 clears the present fault
// - code 27 panel lock release, normally closed
// - codes 32-47 drive general bits 0-15
// - codes 48-51 form four-bit selector
// - code 54 disables torque cap, normally closed
// - terminal and network inputs kept separate
// - regeneration unit sensed only at power-up
// - open thermostat raises regeneration overheat alarm, only once the unit was sensed present
// - per-terminal level: 0 open, 1 closed
// - any active terminal runs shared function, except codes 27 and 54, which need every claiming terminal active
// - fault clear acts on ON-to-OFF edge
module ifa_top #(
  parameter int NUM_TERMINALS = ifa_pkg::NUM_TERMINALS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // terminal pins and their settings
  input wire logic [NUM_TERMINALS-1:0] input_terminal,
  input wire logic [NUM_TERMINALS*8-1:0] code_setting,
  input wire logic [NUM_TERMINALS-1:0] level_setting,
  input wire logic load_defaults,
  // network inputs
  input wire ifa_pkg::ifa_func_type network_func,
  // regeneration unit thermostat pin, closed is high
  input wire logic regen_thermostat,
  // routed functions
  output ifa_pkg::ifa_func_type direct_func,
  output ifa_pkg::ifa_func_type merged_func,
  output logic fault_clear_pulse,
  // regeneration unit status
  output logic regen_present,
  output logic regen_overheat_alarm,
  // settings in force
  output logic [NUM_TERMINALS*8-1:0] active_codes,
  output logic [NUM_TERMINALS-1:0] active_levels
);
  // ************************************************************
  // parameter store
  // ************************************************************
  logic [NUM_TERMINALS*8-1:0] next_codes;
  logic [NUM_TERMINALS-1:0] next_levels;
  logic settings_taken;

  // factory initialisation on reset or on request
  assign next_codes = load_defaults ?
    ifa_pkg::DEFAULT_CODES[NUM_TERMINALS*8-1:0] : code_setting;
  assign next_levels = load_defaults ?
    ifa_pkg::DEFAULT_LEVELS[NUM_TERMINALS-1:0] : level_setting;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      active_codes <= ifa_pkg::DEFAULT_CODES[NUM_TERMINALS*8-1:0];
      active_levels <= ifa_pkg::DEFAULT_LEVELS[NUM_TERMINALS-1:0];
      settings_taken <= 1'b0;
    end else begin
      active_codes <= next_codes;
      active_levels <= next_levels;
      settings_taken <= 1'b1;
    end
  end

  // ************************************************************
  // terminals
  // ************************************************************
  logic [NUM_TERMINALS-1:0] sync_level;
  ifa_pkg::ifa_func_type term_func [NUM_TERMINALS];
  logic [NUM_TERMINALS-1:0] panel_claim;
  logic [NUM_TERMINALS-1:0] torque_claim;

  genvar t;
  generate
    for (t = 0; t < NUM_TERMINALS; t = t + 1) begin : g_term
      ifa_sync #(
        .RESET_VALUE(1'b0)
      ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .pin(input_terminal[t]),
        .level(sync_level[t])
      );
      ifa_term u_term (
        .level(sync_level[t]),
        .nc_sense(active_levels[t]),
        .code(active_codes[t*8 +: 8]),
        .func(term_func[t]),
        .panel_claim(panel_claim[t]),
        .torque_claim(torque_claim[t])
      );
    end
  endgenerate

  // ************************************************************
  // merge
  // ************************************************************
  ifa_pkg::ifa_func_type or_func;
  logic panel_all_on;
  logic torque_all_on;

  // shared functions are or-ed; the two contact-logic functions need
  // every claiming terminal on, and read on when nobody claims them
  always_comb begin
    or_func = '0;
    panel_all_on = 1'b1;
    torque_all_on = 1'b1;
    for (int i = 0; i < NUM_TERMINALS; i++) begin
      or_func = or_func | term_func[i];
      if (panel_claim[i] && !term_func[i].panel_lock_release) begin
        panel_all_on = 1'b0;
      end
      if (torque_claim[i] && !term_func[i].torque_cap_disable) begin
        torque_all_on = 1'b0;
      end
    end
  end

  ifa_pkg::ifa_func_type next_direct;
  ifa_pkg::ifa_func_type next_merged;

  always_comb begin
    next_direct = or_func;
    next_direct.panel_lock_release = panel_all_on;
    next_direct.torque_cap_disable = torque_all_on;
    // network sources join by or, the contact-logic pair by and
    next_merged = next_direct | network_func;
    next_merged.panel_lock_release =
      panel_all_on & network_func.panel_lock_release;
    next_merged.torque_cap_disable =
      torque_all_on & network_func.torque_cap_disable;
  end

  logic clear_prev;
  wire clear_fall;
  // alarm clear acts on release, so a held contact cannot re-clear
  assign clear_fall = clear_prev & ~next_merged.fault_clear;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      direct_func <= '0;
      merged_func <= '0;
      clear_prev <= 1'b0;
      fault_clear_pulse <= 1'b0;
    end else begin
      direct_func <= next_direct;
      merged_func <= next_merged;
      clear_prev <= next_merged.fault_clear;
      fault_clear_pulse <= clear_fall;
    end
  end

  // ************************************************************
  // regeneration unit
  // ************************************************************
  logic thermo_level;
  ifa_pkg::ifa_regen_type regen_state;
  ifa_pkg::ifa_regen_type next_regen_state;

  ifa_sync #(
    .RESET_VALUE(1'b0)
  ) u_thermo_sync (
    .clk(clk),
    .resetn(resetn),
    .pin(regen_thermostat),
    .level(thermo_level)
  );

  logic [2:0] settle_count;
  wire sync_done;
  assign sync_done = (settle_count == 3'(ifa_pkg::SYNC_STAGES + 1));

  // the unit is judged once after power-up, when the synchroniser has
  // settled; a later plug-in cannot move the state out of absent
  always_comb begin
    case (regen_state)
      ifa_pkg::REGEN_WAIT: begin
        next_regen_state = regen_state;
        if (settings_taken && sync_done) begin
          next_regen_state = thermo_level ? ifa_pkg::REGEN_PRESENT :
                                            ifa_pkg::REGEN_ABSENT;
        end
      end
      ifa_pkg::REGEN_PRESENT: next_regen_state = regen_state;
      ifa_pkg::REGEN_ABSENT: next_regen_state = regen_state;
      default: next_regen_state = ifa_pkg::REGEN_WAIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      settle_count <= 3'h0;
    end else if (!sync_done) begin
      settle_count <= settle_count + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      regen_state <= ifa_pkg::REGEN_WAIT;
      regen_present <= 1'b0;
      regen_overheat_alarm <= 1'b0;
    end else begin
      regen_state <= next_regen_state;
      regen_present <= (next_regen_state == ifa_pkg::REGEN_PRESENT);
      // sticky until the fault clear edge; a new open wins over clear
      if (regen_state == ifa_pkg::REGEN_PRESENT && !thermo_level) begin
        regen_overheat_alarm <= 1'b1;
      end else if (clear_fall) begin
        regen_overheat_alarm <= 1'b0;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_default_codes;
    @(posedge clk) $rose(resetn) |->
      active_codes == ifa_pkg::DEFAULT_CODES[NUM_TERMINALS*8-1:0];
  endproperty
  a_default_codes: assert property (p_default_codes)
    else $error("codes not at factory values after reset");

  property p_clear_fall;
    @(posedge clk) disable iff (!resetn)
      merged_func.fault_clear ##1 !merged_func.fault_clear |->
        fault_clear_pulse;
  endproperty
  a_clear_fall: assert property (p_clear_fall)
    else $error("fault clear release gave no pulse");

  property p_clear_not_on_rise;
    @(posedge clk) disable iff (!resetn)
      $rose(merged_func.fault_clear) |-> !fault_clear_pulse;
  endproperty
  a_clear_not_on_rise: assert property (p_clear_not_on_rise)
    else $error("fault clear acted on assertion");

  property p_unused_quiet;
    @(posedge clk) disable iff (!resetn)
      (active_codes == '0) && !network_func.forward_run &&
      (network_func.general_bits == '0) |=>
        !merged_func.forward_run && (merged_func.general_bits == '0);
  endproperty
  a_unused_quiet: assert property (p_unused_quiet)
    else $error("unused terminal drove a function");

  property p_regen_locked;
    @(posedge clk) disable iff (!resetn)
      regen_state == ifa_pkg::REGEN_ABSENT |=>
        regen_state == ifa_pkg::REGEN_ABSENT;
  endproperty
  a_regen_locked: assert property (p_regen_locked)
    else $error("regeneration unit taken up after power-up");

  property p_regen_alarm;
    @(posedge clk) disable iff (!resetn)
      regen_state == ifa_pkg::REGEN_PRESENT && !thermo_level |=>
        regen_overheat_alarm;
  endproperty
  a_regen_alarm: assert property (p_regen_alarm)
    else $error("open thermostat raised no alarm");

  property p_network_or;
    @(posedge clk) disable iff (!resetn)
      network_func.forward_run |=> merged_func.forward_run;
  endproperty
  a_network_or: assert property (p_network_or)
    else $error("network forward run lost");

  // backward run seen from the raw settings, apart from the decoder
  wire [NUM_TERMINALS-1:0] bwd_hit;
  generate
    for (genvar b = 0; b < NUM_TERMINALS; b++) begin : g_bwd
      assign bwd_hit[b] = (sync_level[b] ^ active_levels[b]) &&
        (active_codes[b*8 +: 8] == ifa_pkg::CODE_BACKWARD_RUN);
    end
  endgenerate

  property p_direct_separate;
    @(posedge clk) disable iff (!resetn)
      (bwd_hit == '0) |=> !direct_func.backward_run;
  endproperty
  a_direct_separate: assert property (p_direct_separate)
    else $error("direct backward run without a terminal");

  property p_direct_shared;
    @(posedge clk) disable iff (!resetn)
      (bwd_hit != '0) |=> direct_func.backward_run;
  endproperty
  a_direct_shared: assert property (p_direct_shared)
    else $error("active backward run terminal ignored");

  c_clear: cover property (@(posedge clk) fault_clear_pulse);
  c_regen: cover property (@(posedge clk) regen_overheat_alarm);
  c_fwd: cover property (@(posedge clk) direct_func.forward_run);
endmodule
`default_nettype wire

/* core/ifa_pkg.sv */
// Purpose: shared constants and types for the input function assignment block
// Assumes: 20 MHz clock, synchronous active-low reset
// Notes: assignment codes are the terminal function numbers
`default_nettype none
package ifa_pkg;
  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NUM_TERMINALS = 7;
  localparam int CODE_WIDTH = 8;
  localparam int GP_BITS = 16;
  localparam int SEL_BITS = 4;
  localparam int SYNC_STAGES = 3;

  // ************************************************************
  // assignment codes
  // ************************************************************
  localparam logic [7:0] CODE_UNUSED = 8'h00;
  localparam logic [7:0] CODE_FORWARD_RUN = 8'h01;
  localparam logic [7:0] CODE_BACKWARD_RUN = 8'h02;
  localparam logic [7:0] CODE_HALT_STYLE = 8'h13;
  localparam logic [7:0] CODE_BRAKE_RELEASE = 8'h14;
  localparam logic [7:0] CODE_EXTERNAL_FAULT = 8'h15;
  localparam logic [7:0] CODE_OVERHEAT_HALT = 8'h16;
  localparam logic [7:0] CODE_FAULT_CLEAR = 8'h18;
  localparam logic [7:0] CODE_PANEL_LOCK = 8'h1b;
  localparam logic [7:0] CODE_GP_FIRST = 8'h20;
  localparam logic [7:0] CODE_GP_LAST = 8'h2f;
  localparam logic [7:0] CODE_SEL_FIRST = 8'h30;
  localparam logic [7:0] CODE_SEL_LAST = 8'h33;
  localparam logic [7:0] CODE_TORQUE_CAP = 8'h36;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [55:0] DEFAULT_CODES =
    {8'h16, 8'h14, 8'h18, 8'h30, 8'h13, 8'h02, 8'h01};
  localparam logic [6:0] DEFAULT_LEVELS = 7'h00;

  // ************************************************************
  // routed function bundle
  // ************************************************************
  typedef struct packed {
    logic forward_run;
    logic backward_run;
    logic halt_style;
    logic brake_release;
    logic external_fault_input;
    logic overheat_halt;
    logic fault_clear;
    logic panel_lock_release;
    logic torque_cap_disable;
    logic [15:0] general_bits;
    logic [3:0] op_data_selector_bits;
  } ifa_func_type;

  typedef enum logic [1:0] {
    REGEN_WAIT = 2'b00,
    REGEN_PRESENT = 2'b01,
    REGEN_ABSENT = 2'b10
  } ifa_regen_type;
endpackage
`default_nettype wire

/* core/ifa_sync.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ifa_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // pin and result
  input wire logic pin,
  output logic level
);
  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      level <= RESET_VALUE;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      // a change counts only once the last two stages agree
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end
endmodule
`default_nettype wire

/* core/ifa_term.sv */
// Purpose: one terminal: logic level then code decode
// Assumes: level is already synchronised
// Notes: combinational; result registered in the top
`timescale 1ns/1ps
`default_nettype none
module ifa_term (
  // terminal input
  input wire logic level,
  input wire logic nc_sense,
  input wire logic [7:0] code,
  // decoded function contribution
  output ifa_pkg::ifa_func_type func,
  output logic panel_claim,
  output logic torque_claim
);
  wire active;
  wire is_gp;
  wire is_sel;
  wire [7:0] gp_index;
  wire [7:0] sel_index;

  // normally-closed terminal is active when the contact is open
  assign active = level ^ nc_sense;
  assign is_gp = (code >= ifa_pkg::CODE_GP_FIRST) &&
                 (code <= ifa_pkg::CODE_GP_LAST);
  assign is_sel = (code >= ifa_pkg::CODE_SEL_FIRST) &&
                  (code <= ifa_pkg::CODE_SEL_LAST);
  assign gp_index = code - ifa_pkg::CODE_GP_FIRST;
  assign sel_index = code - ifa_pkg::CODE_SEL_FIRST;
  // codes for contact-logic functions are claimed whatever the level
  assign panel_claim = (code == ifa_pkg::CODE_PANEL_LOCK);
  assign torque_claim = (code == ifa_pkg::CODE_TORQUE_CAP);

  // unused and unknown codes fall through to all zero
  always_comb begin
    func = '0;
    if (active) begin
      func.forward_run = (code == ifa_pkg::CODE_FORWARD_RUN);
      func.backward_run = (code == ifa_pkg::CODE_BACKWARD_RUN);
      func.halt_style = (code == ifa_pkg::CODE_HALT_STYLE);
      func.brake_release = (code == ifa_pkg::CODE_BRAKE_RELEASE);
      func.external_fault_input =
        (code == ifa_pkg::CODE_EXTERNAL_FAULT);
      func.overheat_halt = (code == ifa_pkg::CODE_OVERHEAT_HALT);
      func.fault_clear = (code == ifa_pkg::CODE_FAULT_CLEAR);
      func.panel_lock_release = panel_claim;
      func.torque_cap_disable = torque_claim;
      if (is_gp) begin
        func.general_bits[gp_index[3:0]] = 1'b1;
      end
      if (is_sel) begin
        func.op_data_selector_bits[sel_index[1:0]] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/ifa_contacts.sv */
// Purpose: relays and thermostat contact that feed the terminal pins
// Assumes: wanted levels change just after a clock edge
// Notes: lag holds each change back, to mimic a slow relay
`timescale 1ns/1ps
`default_nettype none
module ifa_contacts (
  // clock
  input wire logic clk,
  // wanted contact state and relay lag in cycles
  input wire logic [6:0] want_pins,
  input wire logic want_thermo,
  input wire logic [3:0] lag,
  // wires into the block
  output logic [6:0] input_terminal,
  output logic regen_thermostat
);
  // ************************************************************
  // contact state
  // ************************************************************
  logic [7:0] shown = 8'h80;
  logic [3:0] wait_cnt = 4'h0;
  logic [7:0] want;
  assign want = {want_thermo, want_pins};
  assign input_terminal = shown[6:0];
  assign regen_thermostat = shown[7];
  // a contact is always driven, open or closed, so no float is modelled
  always @(posedge clk) begin
    if (shown === want) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= lag) begin
      shown <= want;
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* dv/ifa_top_bench.sv */
// Purpose: self-checking bench for terminal function routing
// Assumes: 20 MHz clock, synchronous active-low reset
// Notes: waits are bounded; ten cycles cover the pin synchroniser
`timescale 1ns/1ps
`default_nettype none
module ifa_top_bench;
  // ************************************************************
  // stimulus and wires
  // ************************************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] want_pins = 7'h00;
  logic want_thermo = 1'b1;
  logic [3:0] lag = 4'h0;
  logic [6:0] input_terminal;
  logic regen_thermostat;
  logic [55:0] code_setting = ifa_pkg::DEFAULT_CODES;
  logic [6:0] level_setting = 7'h00;
  logic load_defaults = 1'b0;
  ifa_pkg::ifa_func_type network_func;
  ifa_pkg::ifa_func_type direct_func;
  ifa_pkg::ifa_func_type merged_func;
  ifa_pkg::ifa_func_type net_f;
  logic fault_clear_pulse;
  logic regen_present;
  logic regen_overheat_alarm;
  logic [55:0] active_codes;
  logic [6:0] active_levels;
  int miscompares = 0;
  int num_checks = 0;
  int n;
  always #25 clk = ~clk;

  ifa_contacts u_contacts (.clk(clk), .want_pins(want_pins),
    .want_thermo(want_thermo), .lag(lag),
    .input_terminal(input_terminal), .regen_thermostat(regen_thermostat));

  ifa_top #(.NUM_TERMINALS(7)) u_dut (.clk(clk), .resetn(resetn),
    .input_terminal(input_terminal), .code_setting(code_setting),
    .level_setting(level_setting), .load_defaults(load_defaults),
    .network_func(network_func), .regen_thermostat(regen_thermostat),
    .direct_func(direct_func), .merged_func(merged_func),
    .fault_clear_pulse(fault_clear_pulse), .regen_present(regen_present),
    .regen_overheat_alarm(regen_overheat_alarm),
    .active_codes(active_codes), .active_levels(active_levels));

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic apply(input logic [55:0] c, input logic [6:0] lv,
                       input logic [6:0] p);
    @(posedge clk);
    code_setting <= c;
    level_setting <= lv;
    want_pins <= p;
    settle();
  endtask

  // unclaimed panel lock and torque cap read as active
  function automatic ifa_pkg::ifa_func_type base();
    ifa_pkg::ifa_func_type f;
    f = '0;
    f.panel_lock_release = 1'b1;
    f.torque_cap_disable = 1'b1;
    return f;
  endfunction

  function automatic ifa_pkg::ifa_func_type exp_one(input int c,
                                                    input logic act);
    ifa_pkg::ifa_func_type f;
    f = base();
    case (c)
      1: f.forward_run = act;
      2: f.backward_run = act;
      19: f.halt_style = act;
      20: f.brake_release = act;
      21: f.external_fault_input = act;
      22: f.overheat_halt = act;
      24: f.fault_clear = act;
      27: f.panel_lock_release = act;
      54: f.torque_cap_disable = act;
      default: begin
        if (c >= 32 && c <= 47) f.general_bits[c-32] = act;
        if (c >= 48 && c <= 51) f.op_data_selector_bits[c-48] = act;
      end
    endcase
    return f;
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    network_func = base();
    repeat (2) @(posedge clk);
    #1;
    chk("codes_in_reset", 64'(ifa_pkg::DEFAULT_CODES),
        64'(active_codes));
    chk("levels_in_reset", 64'h0, 64'(active_levels));
    @(posedge clk);
    resetn <= 1'b1;
    n = 0;
    while (regen_present !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    #1;
    if (n >= 20) begin
      chk("regen_wait", 64'h0, 64'(n));
      end_sim();
    end
    chk("regen_present", 64'h1, 64'(regen_present));
    chk("codes_after", 64'(ifa_pkg::DEFAULT_CODES),
        64'(active_codes));
    $display("test reset done");

    for (int c = 0; c < 60; c++) begin
      apply({48'h0, 8'(c)}, 7'h00, 7'h00);
      chk("direct_idle", 64'(exp_one(c, 1'b0)),
          64'(direct_func));
      apply({48'h0, 8'(c)}, 7'h00, 7'h01);
      chk("direct_on", 64'(exp_one(c, 1'b1)),
          64'(direct_func));
      chk("merged_on", 64'(exp_one(c, 1'b1)),
          64'(merged_func));
    end
    $display("test code table done");

    apply({48'h0, ifa_pkg::CODE_FORWARD_RUN}, 7'h01, 7'h00);
    chk("nc_open", 64'h1, 64'(direct_func.forward_run));
    chk("levels", 64'h1, 64'(active_levels));
    apply({48'h0, ifa_pkg::CODE_FORWARD_RUN}, 7'h01, 7'h01);
    chk("nc_closed", 64'h0, 64'(direct_func.forward_run));
    apply({40'h0, 16'h2020}, 7'h00, 7'h02);
    chk("shared_gp", 64'h1, 64'(direct_func.general_bits));
    apply({40'h0, 16'h1b1b}, 7'h00, 7'h01);
    chk("panel_one", 64'h0, 64'(direct_func.panel_lock_release));
    apply({40'h0, 16'h1b1b}, 7'h00, 7'h03);
    chk("panel_both", 64'h1, 64'(direct_func.panel_lock_release));
    apply({24'h0, 32'h3332_3130}, 7'h00, 7'h0a);
    chk("selector", 64'ha,
        64'(direct_func.op_data_selector_bits));
    $display("test sense and sharing done");

    apply(56'h0, 7'h00, 7'h00);
    net_f = base();
    net_f.forward_run = 1'b1;
    net_f.general_bits = 16'ha5a5;
    @(posedge clk);
    network_func <= net_f;
    settle();
    chk("net_direct", 64'(base()), 64'(direct_func));
    chk("net_merged", 64'(net_f), 64'(merged_func));
    @(posedge clk);
    network_func <= base();
    load_defaults <= 1'b1;
    apply(56'h0, 7'h00, 7'h01);
    chk("defaults", 64'(ifa_pkg::DEFAULT_CODES),
        64'(active_codes));
    chk("default_fwd", 64'h1, 64'(direct_func.forward_run));
    @(posedge clk);
    load_defaults <= 1'b0;
    $display("test network and defaults done");

    apply(ifa_pkg::DEFAULT_CODES, 7'h00, 7'h00);
    lag <= 4'h3;
    want_thermo <= 1'b0;
    settle();
    chk("alarm_set", 64'h1, 64'(regen_overheat_alarm));
    want_thermo <= 1'b1;
    apply(ifa_pkg::DEFAULT_CODES, 7'h00, 7'h10);
    chk("pulse_on_press", 64'h0, 64'(fault_clear_pulse));
    chk("alarm_held", 64'h1, 64'(regen_overheat_alarm));
    want_pins <= 7'h00;
    n = 0;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (fault_clear_pulse === 1'b1) n++;
    end
    chk("pulse_count", 64'h1, 64'(n));
    chk("alarm_clear", 64'h0, 64'(regen_overheat_alarm));
    lag <= 4'h0;
    want_thermo <= 1'b0;
    settle();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    settle();
    settle();
    chk("regen_absent", 64'h0, 64'(regen_present));
    want_thermo <= 1'b1;
    settle();
    chk("regen_late", 64'h0, 64'(regen_present));
    $display("test alarm and regen done");
    end_sim();
  end
endmodule
`default_nettype wire
